// ==== hdl/sfr_param_rom.sv ====
// Parameter-table and unique-id read engine of a serial flash, with its output buffer.
// Assumes serial pins already synchronous to core_clk and sclk far slower than core_clk.
//
// Operation
// - Byte 31h returns 4 KB erase opcode 20h
// - Byte 32h: address mode 01b, DTR 0
// - Byte 32h fast-read flags 1,1,1,0; top bit 1
// - 38h encodes 4 waits, 8 mode bits; 39h EBh
// - 3Ah zero waits and modes; 3Bh reads FFh
// - 3Ch encodes 8 waits; 3Dh holds 3Bh
// - 3Eh encodes 4 waits; 3Fh holds BBh
// - 40h reads FEh; 41h..43h all ones
// - 44h,45h ones; 46h zero; 47h FFh
// - 48h,49h ones; 4Ah 4 waits, 8 modes
// - Sector type one: 0Ch, opcode 20h
// - Sector type three: 10h, opcode D8h
// - Sector types two, four: 00h and FFh
// - Unique id read: 5Ah, address 80h, dummy
// - 96-bit id at 80h..8Bh, MSB first
// - Writes ignored during power-up delay
// - Opcode, address, dummy rise; data on fall
// - Address increments per byte, wraps to zero
// - Read rejected while write cycle busy
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Byte buffer
// ****************************************
module sfr_fifo #(
	parameter int WIDTH = sfr_pkg::SFR_FIFO_WIDTH,
	parameter int DEPTH = sfr_pkg::SFR_FIFO_DEPTH
) (
	input wire logic core_clk, // Core clock
	input wire logic rst, // Synchronous reset
	input wire logic flush, // Empties the buffer
	input wire logic in_valid, // Write request
	output logic in_ready, // Room for one more word
	input wire logic [WIDTH-1:0] in_data, // Write word
	output logic out_valid, // Word available
	input wire logic out_ready, // Drain request
	output logic [WIDTH-1:0] out_data // Oldest word
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wr;
		logic [PW-1:0] rd;
		logic [PW:0] count;
	} sfr_fifo_state_t;

	sfr_fifo_state_t st_reg;
	sfr_fifo_state_t st_next;
	logic do_push;
	logic do_pop;

	assign in_ready = st_reg.count != (PW+1)'(DEPTH);
	assign out_valid = st_reg.count != '0;
	assign out_data = st_reg.mem[st_reg.rd];
	assign do_push = in_valid && in_ready;
	assign do_pop = out_valid && out_ready;

	always_comb begin
		st_next = st_reg;
		if (flush) begin
			st_next.wr = '0;
			st_next.rd = '0;
			st_next.count = '0;
		end else begin
			if (do_push) begin
				st_next.mem[st_reg.wr] = in_data;
				st_next.wr = (st_reg.wr == PW'(DEPTH - 1)) ? '0 : PW'(st_reg.wr + 1'b1);
			end
			if (do_pop) begin
				st_next.rd = (st_reg.rd == PW'(DEPTH - 1)) ? '0 : PW'(st_reg.rd + 1'b1);
			end
			if (do_push && !do_pop) begin
				st_next.count = (PW+1)'(st_reg.count + 1'b1);
			end else if (do_pop && !do_push) begin
				st_next.count = (PW+1)'(st_reg.count - 1'b1);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule // sfr_fifo

// ****************************************
// Read engine
// ****************************************
module sfr_param_rom #(
	parameter int unsigned PUW_CYCLES = sfr_pkg::SFR_PUW_CYCLES,
	parameter logic [7:0] QUAD_ALL_OPCODE = sfr_pkg::SFR_QUAD_ALL_OP_DFLT
) (
	input wire logic core_clk, // Core clock
	input wire logic rst, // Synchronous reset, power-up
	input wire logic spi_sclk, // Host serial clock
	input wire logic spi_cs_n, // Chip select, active low
	input wire logic spi_di, // Serial data from host
	output logic spi_do, // Serial data to host
	output logic spi_do_oe_n, // Output enable, low drives
	input wire logic [95:0] unique_id, // Per-die nonvolatile id
	input wire logic write_busy, // Erase, program or write in progress
	input wire logic write_cmd, // Write instruction decoded, pulse
	output logic write_cmd_accept, // Write instruction let through
	output logic write_inhibit, // Power-up write lockout active
	output logic read_rejected, // Read refused while busy, pulse
	output logic quad_peripheral_mode // Held low; quad mode not in block
);
	import sfr_pkg::*;

	typedef struct packed {
		sfr_state_t state;
		logic sclk_q;
		logic [2:0] bit_cnt;
		logic [7:0] rx_sh;
		logic [1:0] addr_cnt;
		logic [7:0] ptr;
		logic [7:0] tx_sh;
		logic [3:0] tx_left;
		logic do_bit;
		logic oe_n;
		logic [SFR_PUW_CNT_W-1:0] puw_cnt;
		logic inhibit;
		logic wr_accept;
		logic rejected;
	} sfr_state_all_t;

	sfr_state_all_t st_reg;
	sfr_state_all_t st_next;
	logic [7:0] uid_byte [SFR_UID_BYTES];
	logic [7:0] rom_data;
	logic rise;
	logic fall;
	logic [7:0] rx_byte;
	logic prod_valid;
	logic prod_ready;
	logic cons_valid;
	logic cons_ready;
	logic [7:0] cons_data;

	// ****************************************
	// Id split, first byte is the top one
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < SFR_UID_BYTES; gi++) begin : g_uid
			assign uid_byte[gi] = unique_id[95 - 8*gi -: 8];
		end
	endgenerate

	// ****************************************
	// Table lookup by byte pointer
	// ****************************************
	always_comb begin
		rom_data = SFR_BLANK;
		if (st_reg.ptr <= SFR_HDR_LAST) begin
			rom_data = SFR_HDR_ROM[st_reg.ptr[3:0]];
		end else if (st_reg.ptr == SFR_OFS_QUAD_ALL_OP) begin
			rom_data = QUAD_ALL_OPCODE;
		end else if (st_reg.ptr >= SFR_PT_BASE && st_reg.ptr <= SFR_PT_LAST) begin
			rom_data = SFR_PT_ROM[6'(st_reg.ptr - SFR_PT_BASE)];
		end else if (st_reg.ptr >= SFR_UID_BASE && st_reg.ptr <= SFR_UID_LAST) begin
			rom_data = uid_byte[4'(st_reg.ptr - SFR_UID_BASE)];
		end
	end

	// ****************************************
	// Prefetch into buffer, drain on falling edges
	// ****************************************
	assign rise = spi_sclk && !st_reg.sclk_q;
	assign fall = !spi_sclk && st_reg.sclk_q;
	assign rx_byte = {st_reg.rx_sh[6:0], spi_di};
	assign prod_valid = !spi_cs_n && (st_reg.state == SFR_ST_DUMMY || st_reg.state == SFR_ST_DATA);
	assign cons_ready = !spi_cs_n && fall && st_reg.state == SFR_ST_DATA && st_reg.tx_left == 4'h0;

	sfr_fifo #(
		.WIDTH(SFR_FIFO_WIDTH),
		.DEPTH(SFR_FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.flush(spi_cs_n),
		.in_valid(prod_valid),
		.in_ready(prod_ready),
		.in_data(rom_data),
		.out_valid(cons_valid),
		.out_ready(cons_ready),
		.out_data(cons_data)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_next = st_reg;
		st_next.sclk_q = spi_sclk;
		st_next.rejected = 1'b0;
		if (prod_valid && prod_ready) begin
			st_next.ptr = 8'(st_reg.ptr + 1'b1);
		end
		if (spi_cs_n) begin
			st_next.state = SFR_ST_CMD;
			st_next.bit_cnt = '0;
			st_next.addr_cnt = '0;
			st_next.tx_left = '0;
			st_next.oe_n = 1'b1;
		end else if (rise && st_reg.state != SFR_ST_DATA && st_reg.state != SFR_ST_IGNORE) begin
			st_next.rx_sh = rx_byte;
			st_next.bit_cnt = 3'(st_reg.bit_cnt + 1'b1);
			if (st_reg.bit_cnt == SFR_BIT_LAST) begin
				unique case (st_reg.state)
					SFR_ST_CMD: begin
						if (rx_byte == SFR_OP_READ_PARAM && !write_busy) begin
							st_next.state = SFR_ST_ADDR;
						end else begin
							st_next.state = SFR_ST_IGNORE;
							st_next.rejected = rx_byte == SFR_OP_READ_PARAM;
						end
					end
					SFR_ST_ADDR: begin
						st_next.addr_cnt = 2'(st_reg.addr_cnt + 1'b1);
						if (st_reg.addr_cnt == SFR_ADDR_LAST_BYTE) begin
							st_next.ptr = rx_byte;
							st_next.state = SFR_ST_DUMMY;
						end
					end
					SFR_ST_DUMMY: begin
						st_next.state = SFR_ST_DATA;
						st_next.tx_left = '0;
					end
					default: begin
						st_next.state = SFR_ST_IGNORE;
					end
				endcase
			end
		end else if (fall && st_reg.state == SFR_ST_DATA) begin
			st_next.oe_n = 1'b0;
			if (st_reg.tx_left == 4'h0) begin
				st_next.tx_sh = cons_valid ? cons_data : SFR_BLANK;
				st_next.do_bit = cons_valid ? cons_data[7] : 1'b1;
				st_next.tx_left = 4'h7;
			end else begin
				st_next.do_bit = st_reg.tx_sh[6];
				st_next.tx_sh = {st_reg.tx_sh[6:0], 1'b1};
				st_next.tx_left = 4'(st_reg.tx_left - 1'b1);
			end
		end
		// Power-up lockout
		if (st_reg.inhibit) begin
			if (st_reg.puw_cnt == SFR_PUW_CNT_W'(PUW_CYCLES - 1)) begin
				st_next.inhibit = 1'b0;
			end else begin
				st_next.puw_cnt = SFR_PUW_CNT_W'(st_reg.puw_cnt + 1'b1);
			end
		end
		st_next.wr_accept = write_cmd && !st_reg.inhibit;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.state <= SFR_ST_CMD;
			st_reg.sclk_q <= 1'b0;
			st_reg.do_bit <= 1'b1;
			st_reg.oe_n <= 1'b1;
			st_reg.inhibit <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign spi_do = st_reg.do_bit;
	assign spi_do_oe_n = st_reg.oe_n;
	assign write_cmd_accept = st_reg.wr_accept;
	assign write_inhibit = st_reg.inhibit;
	assign read_rejected = st_reg.rejected;
	assign quad_peripheral_mode = 1'b0;
endmodule // sfr_param_rom

`default_nettype wire

// ==== hdl/sfr_pkg.sv ====
// Constants, table contents and state codes of the parameter and unique-id store.
// Assumes a 200 MHz core clock and the host serial pins sampled in that domain.
package sfr_pkg;

	// ****************************************
	// Instruction and address layout
	// ****************************************
	localparam logic [7:0] SFR_OP_READ_PARAM = 8'h5A;
	localparam logic [1:0] SFR_ADDR_LAST_BYTE = 2'h2;
	localparam logic [2:0] SFR_BIT_LAST = 3'h7;
	localparam logic [7:0] SFR_HDR_LAST = 8'h0F;
	localparam logic [7:0] SFR_PT_BASE = 8'h30;
	localparam logic [7:0] SFR_PT_LAST = 8'h53;
	localparam logic [7:0] SFR_OFS_QUAD_ALL_OP = 8'h4B;
	localparam logic [7:0] SFR_UID_BASE = 8'h80;
	localparam logic [7:0] SFR_UID_LAST = 8'h8B;
	localparam logic [7:0] SFR_BLANK = 8'hFF;
	localparam logic [7:0] SFR_QUAD_ALL_OP_DFLT = 8'hFF;
	localparam int SFR_UID_BYTES = 12;

	// ****************************************
	// Header bytes 00h..0Fh
	// ****************************************
	localparam logic [7:0] SFR_HDR_ROM [16] = '{
		8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h00, 8'hFF,
		8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF
	};

	// ****************************************
	// Parameter table bytes 30h..53h
	// ****************************************
	localparam logic [7:0] SFR_PT_ROM [36] = '{
		8'hE5, 8'h20, 8'hB3, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F,
		8'h44, 8'hEB, 8'h00, 8'hFF, 8'h08, 8'h3B, 8'h04, 8'hBB,
		8'hFE, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF,
		8'hFF, 8'hFF, 8'h44, 8'hFF, 8'h0C, 8'h20, 8'h00, 8'hFF,
		8'h10, 8'hD8, 8'h00, 8'hFF
	};

	// ****************************************
	// Timing
	// ****************************************
	localparam int SFR_CLK_MHZ = 200;
	localparam int SFR_PUW_MS = 10;
	localparam int SFR_PUW_CYCLES = SFR_PUW_MS * 1000 * SFR_CLK_MHZ;
	localparam int SFR_PUW_CNT_W = 22;

	// ****************************************
	// Buffer shape
	// ****************************************
	localparam int SFR_FIFO_WIDTH = 8;
	localparam int SFR_FIFO_DEPTH = 32;

	typedef enum logic [2:0] {
		SFR_ST_CMD = 3'b000,
		SFR_ST_ADDR = 3'b001,
		SFR_ST_DUMMY = 3'b010,
		SFR_ST_DATA = 3'b011,
		SFR_ST_IGNORE = 3'b100
	} sfr_state_t;

endpackage

// ==== sim/sfr_host.sv ====
// Host controller model: mode 0 read frames, samples data out.
// Assumes core_clk; four core cycles per serial clock level.
`timescale 1ns/1ps
`default_nettype none
module sfr_host (
	input wire logic core_clk, // Core clock
	output logic spi_sclk, // Serial clock
	output logic spi_cs_n, // Select, active low
	output logic spi_di, // Data to device
	input wire logic spi_do, // Data from device
	input wire logic spi_do_oe_n // Low while device drives
);
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_di = 1'b0;
	end
	task automatic half();
		repeat (4) @(posedge core_clk);
	endtask
	task automatic frame(input logic [7:0] op, input logic [7:0] adr, input int n,
		output logic [7:0] q[$]);
		logic [39:0] hdr;
		logic [7:0] b;
		hdr = {op, 16'h0000, adr, 8'h00};
		q = {};
		spi_cs_n <= 1'b0;
		for (int i = 39; i >= 0; i--) begin
			spi_sclk <= 1'b0;
			spi_di <= hdr[i];
			half();
			spi_sclk <= 1'b1;
			half();
		end
		// Released line shows the inverse
		spi_di <= ~hdr[0];
		for (int k = 0; k < n; k++) begin
			for (int j = 7; j >= 0; j--) begin
				spi_sclk <= 1'b0;
				half();
				b[j] = spi_do_oe_n ? 1'bz : spi_do;
				spi_sclk <= 1'b1;
				half();
			end
			q.push_back(b);
		end
		spi_sclk <= 1'b0;
		half();
		spi_cs_n <= 1'b1;
		half();
	endtask
endmodule // sfr_host
`default_nettype wire

// ==== sim/sfr_param_rom_checker.sv ====
// Port-level checker for the parameter and unique-id store.
// Assumes the top module's ports; bound below.
`timescale 1ns/1ps
`default_nettype none
module sfr_param_rom_checker #(
	parameter int unsigned PUW_CYCLES = 50
) (
	input wire logic core_clk, // Core clock
	input wire logic rst, // Sync reset
	input wire logic spi_sclk, // Serial clock
	input wire logic spi_cs_n, // Select, active low
	input wire logic spi_do, // Data out
	input wire logic spi_do_oe_n, // Out enable, low drives
	input wire logic write_cmd, // Write request
	input wire logic write_cmd_accept, // Write let through
	input wire logic write_inhibit, // Lockout
	input wire logic read_rejected, // Refusal pulse
	input wire logic quad_peripheral_mode // Quad mode
);
	logic [31:0] up_cnt;
	logic [3:0] fall_age;
	logic sclk_q;
	logic rej_frame;
	always_ff @(posedge core_clk) begin
		sclk_q <= spi_sclk;
		if (rst || (sclk_q && !spi_sclk)) begin
			fall_age <= 4'h0;
		end else if (fall_age != 4'hF) begin
			fall_age <= fall_age + 4'h1;
		end
		up_cnt <= rst ? 32'h0 : up_cnt + 32'h1;
		rej_frame <= (rst || spi_cs_n) ? 1'b0 : (rej_frame || read_rejected);
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_cmd_open;
		write_cmd && !write_inhibit;
	endsequence
	a_accept_gate: assert property (s_cmd_open |=> write_cmd_accept)
		else $error("write not let through");
	a_accept_cause: assert property (write_cmd_accept |-> $past(write_cmd) && !$past(write_inhibit))
		else $error("write let through without cause");
	a_inhibit_early: assert property (up_cnt + 32'h2 < PUW_CYCLES |-> write_inhibit)
		else $error("lockout ended early");
	a_inhibit_late: assert property (up_cnt > PUW_CYCLES + 32'h2 |-> !write_inhibit)
		else $error("lockout too long");
	a_oe_idle: assert property ($past(spi_cs_n) |-> spi_do_oe_n)
		else $error("output driven while deselected");
	a_oe_first_fall: assert property ($fell(spi_do_oe_n) |-> !spi_cs_n && fall_age <= 4'h3)
		else $error("output enabled off a falling edge");
	a_do_on_fall: assert property ($changed(spi_do) && !spi_do_oe_n && $past(!spi_do_oe_n)
		|-> fall_age <= 4'h3)
		else $error("data changed off a falling edge");
	a_reject_pulse: assert property (read_rejected |=> !read_rejected)
		else $error("refusal not a pulse");
	a_reject_quiet: assert property (rej_frame |-> spi_do_oe_n)
		else $error("refused read drove data");
	a_quad_off: assert property (!quad_peripheral_mode)
		else $error("quad mode raised");
endmodule // sfr_param_rom_checker
bind sfr_param_rom sfr_param_rom_checker #(.PUW_CYCLES(PUW_CYCLES)) chk_u (.core_clk(core_clk),
	.rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_do(spi_do),
	.spi_do_oe_n(spi_do_oe_n), .write_cmd(write_cmd), .write_cmd_accept(write_cmd_accept),
	.write_inhibit(write_inhibit), .read_rejected(read_rejected),
	.quad_peripheral_mode(quad_peripheral_mode));
`default_nettype wire

// ==== sim/test_sfr_param_rom.sv ====
// Testbench of the parameter and unique-id store.
// Assumes sfr_host as the serial host and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_sfr_param_rom;
	import sfr_pkg::*;
	localparam int unsigned PUW = 50;
	localparam logic [7:0] QUAD_OP = 8'hA5;
	localparam logic [7:0] HDR [16] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h00,
		8'hFF, 8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF};
	localparam logic [7:0] PT [36] = '{8'hE5, 8'h20, 8'hB3, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'h0F, 8'h44, 8'hEB, 8'h00, 8'hFF, 8'h08, 8'h3B, 8'h04, 8'hBB, 8'hFE, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h44, QUAD_OP, 8'h0C, 8'h20,
		8'h00, 8'hFF, 8'h10, 8'hD8, 8'h00, 8'hFF};
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic write_busy = 1'b0;
	logic write_cmd = 1'b0;
	logic [95:0] unique_id = 96'h0;
	logic spi_sclk, spi_cs_n, spi_di, spi_do, spi_do_oe_n;
	logic write_cmd_accept, write_inhibit, read_rejected, quad_peripheral_mode;
	logic [7:0] q[$];
	int n_errors = 0;
	int check_count = 0;
	int rej_seen = 0;
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (read_rejected === 1'b1) rej_seen++;
	end
	sfr_param_rom #(.PUW_CYCLES(PUW), .QUAD_ALL_OPCODE(QUAD_OP)) dut_u (.core_clk(core_clk),
		.rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_di(spi_di),
		.spi_do(spi_do), .spi_do_oe_n(spi_do_oe_n), .unique_id(unique_id),
		.write_busy(write_busy), .write_cmd(write_cmd), .write_cmd_accept(write_cmd_accept),
		.write_inhibit(write_inhibit), .read_rejected(read_rejected),
		.quad_peripheral_mode(quad_peripheral_mode));
	sfr_host host_u (.core_clk(core_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
		.spi_di(spi_di), .spi_do(spi_do), .spi_do_oe_n(spi_do_oe_n));
	function automatic logic [7:0] exp_byte(input logic [7:0] a);
		if (a <= 8'h0F) return HDR[a[3:0]];
		if (a >= 8'h30 && a <= 8'h53) return PT[a - 8'h30];
		if (a >= SFR_UID_BASE && a <= SFR_UID_LAST) return unique_id[95 - 8 * int'(a - 8'h80) -: 8];
		return 8'hFF;
	endfunction
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_read(input logic [7:0] adr, input int n);
		host_u.frame(SFR_OP_READ_PARAM, adr, n, q);
		foreach (q[i]) cmp("read byte", exp_byte(adr + 8'(i)), q[i]);
		$display("test read at %h done", adr);
	endtask
	task automatic chk_refused(input logic [7:0] op, input int rej_exp);
		host_u.frame(op, 8'h30, 2, q);
		foreach (q[i]) cmp("refused byte", 8'hzz, q[i]);
		cmp("reject count", 8'(rej_exp), 8'(rej_seen));
		$display("test refusal %h done", op);
	endtask
	task automatic pulse_write(input logic [7:0] exp);
		write_cmd <= 1'b1;
		@(posedge core_clk);
		write_cmd <= 1'b0;
		#1;
		cmp("write accept", exp, {7'h0, write_cmd_accept});
		@(posedge core_clk);
	endtask
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		test_done();
	end
	initial begin
		void'($urandom(23));
		unique_id <= {$urandom, $urandom, $urandom};
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		cmp("inhibit", 8'h01, {7'h0, write_inhibit});
		cmp("oe_n", 8'h01, {7'h0, spi_do_oe_n});
		pulse_write(8'h00);
		repeat (PUW + 5) @(posedge core_clk);
		cmp("inhibit", 8'h00, {7'h0, write_inhibit});
		pulse_write(8'h01);
		for (int i = 0; i < 20; i++) begin
			@(posedge core_clk);
			write_cmd <= 1'($urandom);
		end
		write_cmd <= 1'b0;
		$display("test lockout done");
		chk_read(8'h30, 36);
		chk_read(SFR_UID_BASE, 12);
		chk_read(8'hFE, 4);
		write_busy <= 1'b1;
		chk_refused(SFR_OP_READ_PARAM, 1);
		write_busy <= 1'b0;
		chk_refused(8'h5B ^ 8'({$urandom} & 32'hF0), 1);
		for (int i = 0; i < 4; i++) begin
			unique_id <= {$urandom, $urandom, $urandom};
			chk_read(8'($urandom), 1 + int'($urandom % 6));
		end
		test_done();
	end
endmodule // test_sfr_param_rom
`default_nettype wire
